// *** hw/srlmc_core.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Upsampling chain uses zero to three doubling low-pass stages.
// - Upsample codes 00,01,03,04 give 1x,2x,4x,8x with data rate limits.
// - Modes 0-3 use four converters with fixed lane, sample, octet counts.
// - Modes 4-7 use two converters, modes 9 and 10 one converter.
// - Lane rate is 20 x data rate x M / L, within 1.42-10.64 Gbps.
// - Dense packing is set exactly when one octet per frame per lane.
// - Resolution and bits per sample are both sixteen in every mode.
// - Modes 0, 4 and 9 need 32 frames per multiframe; others allow 16.
// - Two-link select in modes 4-7, 9 and 10 gives two separately resettable links, identical parameters.
// - Scrambling bit enables descrambling of received data.
// - Link page select steers paged accesses to link 0 or link 1.
// - Lane enable mask equals two to the L, minus one; its second register reads zero with one link.
// - Each set idle-lane bit at 0x201 powers off that serial lane input.
// - Field-sum method adds L-1, M-1, K-1, N-1, Np-1, S-1, flags and version.
// - Register-sum method adds packed configuration registers 0x450 to 0x45A.
// - Sum method bit: 0 sums fields, 1 sums packed registers.
// - Converter shutdown mask follows converter count and two-link selection.
// - Pair B clock shut down with 0x40 when DAC2 and DAC3 off.
// - SERDES double rate, oversample and divider follow the lane rate band.
// - Equalizer select 1 gives low power, 0 gives full equalization.
// - Receiver supports subclass 0 and subclass 1, chosen by configuration.
// - Subclass 1 aligns multiframe timing to sysref; subclass 0 ignores it.
module srlmc_core (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [srlmc_pkg::ADDR_W-1:0] cfg_addr_in,
  input wire logic [srlmc_pkg::DATA_W-1:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  output logic [srlmc_pkg::DATA_W-1:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Link timing pin
  input wire logic sysref_in,
  // Link and lane controls
  output logic [1:0] link_run_out,
  output logic descramble_enable_out,
  output logic subclass_out,
  output logic lmfc_pulse_out,
  output logic [7:0] lane_enable_out,
  output logic [7:0] idle_lane_shutdown_out,
  output logic [7:0] lane_zero_config_sum_out,
  // Converter, clock and SERDES controls
  output logic [1:0] upsample_stages_out,
  output logic [3:0] converter_shutdown_mask_out,
  output logic [7:0] pair_b_clock_shutdown_out,
  output logic serdes_double_rate_out,
  output logic cdr_oversample_select_out,
  output logic [1:0] serdes_loop_divider_out,
  output logic equalizer_power_select_out,
  output logic config_error_out
);
  import srlmc_pkg::*;

  srlmc_cfg_if cfg ();
  srlmc_mode_decode u_decode (.cfg(cfg));
  srlmc_config_sum u_sum (.cfg(cfg));

  srlmc_cfg_t staged, next_staged, active, next_active;
  logic [1:0] link_en, next_link_en;
  logic [1:0] link_reset, next_link_reset;
  logic page, next_page;
  logic [7:0] next_idle_lane;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic sysref_meta, sysref_sync, sysref_prev;
  logic sysref_rise;
  logic [4:0] lmfc_cnt, next_lmfc_cnt;
  logic [11:0] data_rate, rate_limit;
  logic [17:0] lane_prod, lane_rate;
  srlmc_band_t band;
  logic [4:0] err;
  logic [7:0] lane_mask;
  logic [7:0] lane_en1;
  logic [1:0] next_run;
  logic [7:0] next_lane_en, next_pair_clk;
  logic [3:0] next_shut;
  logic next_double, next_ovs;
  logic [1:0] next_div;

  function automatic logic [1:0] upsample_shift(input logic [7:0] code);
    case (code)
      UPS_2X: return 2'd1;
      UPS_4X: return 2'd2;
      UPS_8X: return 2'd3;
      default: return 2'd0;
    endcase
  endfunction

  function automatic logic [1:0] log2_small(input logic [3:0] v);
    case (v)
      4'd2: return 2'd1;
      4'd4: return 2'd2;
      4'd8: return 2'd3;
      default: return 2'd0;
    endcase
  endfunction

  assign cfg.mode = active.mode;
  assign cfg.two_link = active.opt[OPT_TWO_LINK_BIT];
  assign cfg.k32 = active.opt[OPT_K32_BIT];
  assign cfg.scramble = active.opt[OPT_SCRAMBLE_BIT];
  assign cfg.subclass = active.subclass;
  assign cfg.sum_method = active.sum_method;
  assign cfg.dev_id = active.dev_id;
  assign cfg.bank_id = active.bank_id;

  // Register writes land in the staged copy; link enables, page, link resets and idle-lane bits act at once.
  always_comb begin
    next_staged = staged;
    next_link_en = link_en;
    next_link_reset = link_reset;
    next_page = page;
    next_idle_lane = idle_lane_shutdown_out;
    if (cfg_wr_in) begin
      unique case (cfg_addr_in)
        REG_MODE: next_staged.mode = cfg_wdata_in[3:0];
        REG_UPSAMPLE: next_staged.ups = cfg_wdata_in;
        REG_LINK_OPT: next_staged.opt = cfg_wdata_in[3:0];
        REG_DAC_LO: next_staged.dac[7:0] = cfg_wdata_in;
        REG_DAC_HI: next_staged.dac[11:8] = cfg_wdata_in[3:0];
        REG_PACK_FIRST: next_staged.dev_id = cfg_wdata_in;
        REG_PACK_BANK: next_staged.bank_id = cfg_wdata_in;
        REG_PAGE: next_page = cfg_wdata_in[0];
        REG_LINK_RESET: next_link_reset[page] = cfg_wdata_in[0];
        REG_IDLE_LANE: next_idle_lane = cfg_wdata_in;
        REG_LINK_CTRL: begin
          next_link_en = cfg_wdata_in[1:0];
          next_staged.subclass = cfg_wdata_in[LC_SUBCLASS_BIT];
          next_staged.sum_method = cfg_wdata_in[LC_SUM_BIT];
        end
        default: ;
      endcase
    end
    // A running link never sees a half-changed parameter set.
    next_active = active;
    if (link_en == 2'b00 || next_link_en == 2'b00) begin
      next_active = next_staged;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      staged <= '{mode: 4'd0, ups: UPS_1X, opt: RESET_OPT, default: '0};
      active <= '{mode: 4'd0, ups: UPS_1X, opt: RESET_OPT, default: '0};
      link_en <= 2'b00;
      link_reset <= 2'b00;
      page <= 1'b0;
      idle_lane_shutdown_out <= 8'h00;
    end else begin
      staged <= next_staged;
      active <= next_active;
      link_en <= next_link_en;
      link_reset <= next_link_reset;
      page <= next_page;
      idle_lane_shutdown_out <= next_idle_lane;
    end
  end

  // Register reads answer one cycle later; unmapped offsets read zero.
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = cfg_rd_in;
    if (cfg_rd_in) begin
      if (cfg_addr_in >= REG_PACK_FIRST && cfg_addr_in <= REG_PACK_LAST) begin
        next_rdata = cfg.packed_cfg[4'(cfg_addr_in - REG_PACK_FIRST)];
      end else begin
        unique case (cfg_addr_in)
          REG_MODE: next_rdata = {4'd0, staged.mode};
          REG_UPSAMPLE: next_rdata = staged.ups;
          REG_LINK_OPT: next_rdata = {4'd0, staged.opt};
          REG_DAC_LO: next_rdata = staged.dac[7:0];
          REG_DAC_HI: next_rdata = {4'd0, staged.dac[11:8]};
          REG_PAGE: next_rdata = {7'd0, page};
          REG_LINK_RESET: next_rdata = {7'd0, link_reset[page]};
          REG_STATUS: next_rdata = {3'd0, err};
          REG_LANE_EN0: next_rdata = lane_mask;
          REG_LANE_EN1: next_rdata = lane_en1;
          REG_CFG_SUM: next_rdata = lane_zero_config_sum_out;
          REG_POWER: next_rdata = {pair_b_clock_shutdown_out[7:4], converter_shutdown_mask_out};
          REG_SERDES: next_rdata = {4'd0, serdes_double_rate_out, cdr_oversample_select_out,
            serdes_loop_divider_out};
          REG_IDLE_LANE: next_rdata = idle_lane_shutdown_out;
          REG_LINK_CTRL: next_rdata = {1'b0, staged.sum_method, 2'd0, staged.subclass, 1'b0,
            link_en};
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= 8'h00;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rdata_out <= next_rdata;
      cfg_rvalid_out <= next_rvalid;
    end
  end

  // Rates are in MHz and Mbps; L and M are powers of two, so shifts multiply by M and divide by L.
  always_comb begin
    data_rate = active.dac >> upsample_shift(active.ups);
    lane_prod = (18'(data_rate) * 18'(LANE_RATE_MULT)) << log2_small({1'b0, cfg.m});
    lane_rate = lane_prod >> log2_small(cfg.l);
    if (lane_rate >= LANE_MIN && lane_rate <= SLOW_MAX) begin
      band = SRLMC_BAND_SLOW;
    end else if (lane_rate >= MID_MIN && lane_rate <= MID_MAX) begin
      band = SRLMC_BAND_MID;
    end else if (lane_rate >= FAST_MIN && lane_rate <= LANE_MAX) begin
      band = SRLMC_BAND_FAST;
    end else begin
      band = SRLMC_BAND_NONE;
    end
    rate_limit = MAX_DATA_LOW;
    if (active.ups == UPS_4X) begin
      rate_limit = MAX_DATA_4X;
    end else if (active.ups == UPS_8X) begin
      rate_limit = MAX_DATA_8X;
    end
    err[0] = !cfg.mode_ok;
    err[1] = !(active.ups inside {UPS_1X, UPS_2X, UPS_4X, UPS_8X});
    err[2] = !cfg.k32 && (active.mode inside {4'd0, 4'd4, 4'd9});
    err[3] = data_rate > rate_limit;
    err[4] = band == SRLMC_BAND_NONE;
    lane_mask = 8'((9'd1 << cfg.l) - 9'd1);
    lane_en1 = cfg.two_link ? lane_mask : 8'h00;
  end

  // Steering outputs follow the applied configuration.
  always_comb begin
    next_run[0] = link_en[0] && !link_reset[0] && err == 5'd0;
    next_run[1] = link_en[1] && cfg.two_link && !link_reset[1] && err == 5'd0;
    next_lane_en = cfg.two_link ? {lane_mask[3:0], lane_mask[3:0]} : lane_mask;
    if (cfg.m == 3'd1) begin
      next_shut = cfg.two_link ? SHUT_ONE_DUAL : SHUT_ONE_SINGLE;
    end else if (cfg.m == 3'd2 && !cfg.two_link) begin
      next_shut = SHUT_TWO_SINGLE;
    end else begin
      next_shut = SHUT_NONE;
    end
    // The mask lists DAC0 in its top bit, so DAC2 and DAC3 sit in the two low bits.
    next_pair_clk = (next_shut[1:0] == 2'b11) ? PAIR_CLK_OFF : PAIR_CLK_ON;
    unique case (band)
      SRLMC_BAND_SLOW: {next_double, next_ovs, next_div} = {1'b0, 1'b1, 2'd2};
      SRLMC_BAND_MID: {next_double, next_ovs, next_div} = {1'b0, 1'b0, 2'd1};
      SRLMC_BAND_FAST: {next_double, next_ovs, next_div} = {1'b1, 1'b0, 2'd0};
      SRLMC_BAND_NONE: {next_double, next_ovs, next_div} = {1'b0, 1'b1, 2'd2};
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      link_run_out <= 2'b00;
      descramble_enable_out <= 1'b0;
      subclass_out <= 1'b0;
      lane_enable_out <= 8'h00;
      lane_zero_config_sum_out <= 8'h00;
      upsample_stages_out <= 2'd0;
      converter_shutdown_mask_out <= SHUT_NONE;
      pair_b_clock_shutdown_out <= PAIR_CLK_ON;
      serdes_double_rate_out <= 1'b0;
      cdr_oversample_select_out <= 1'b1;
      serdes_loop_divider_out <= 2'd2;
      equalizer_power_select_out <= 1'b0;
      config_error_out <= 1'b0;
    end else begin
      link_run_out <= next_run;
      descramble_enable_out <= cfg.scramble;
      subclass_out <= active.subclass;
      lane_enable_out <= next_lane_en;
      lane_zero_config_sum_out <= cfg.cfg_sum;
      upsample_stages_out <= upsample_shift(active.ups);
      converter_shutdown_mask_out <= next_shut;
      pair_b_clock_shutdown_out <= next_pair_clk;
      serdes_double_rate_out <= next_double;
      cdr_oversample_select_out <= next_ovs;
      serdes_loop_divider_out <= next_div;
      equalizer_power_select_out <= active.opt[OPT_EQ_BIT];
      config_error_out <= err != 5'd0;
    end
  end

  // The multiframe counter ticks once per clock as a frame stand-in.
  always_comb begin
    sysref_rise = sysref_sync && !sysref_prev;
    if (active.subclass && sysref_rise) begin
      next_lmfc_cnt = 5'd0;
    end else if (lmfc_cnt == (cfg.k32 ? 5'd31 : 5'd15)) begin
      next_lmfc_cnt = 5'd0;
    end else begin
      next_lmfc_cnt = lmfc_cnt + 5'd1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_prev <= 1'b0;
      lmfc_cnt <= 5'd0;
      lmfc_pulse_out <= 1'b0;
    end else begin
      sysref_meta <= sysref_in;
      sysref_sync <= sysref_meta;
      sysref_prev <= sysref_sync;
      lmfc_cnt <= next_lmfc_cnt;
      lmfc_pulse_out <= next_lmfc_cnt == 5'd0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  ups_stages_a: assert property (
    active.ups == UPS_8X |=> upsample_stages_out == 2'd3)
    else $error("Upsample stage count wrong.");
  rate_limit_a: assert property (
    active.ups == UPS_4X && data_rate > MAX_DATA_4X |=> config_error_out)
    else $error("Data rate limit not flagged.");
  mode_quad_a: assert property (
    active.mode == 4'd3 |-> cfg.m == 3'd4 && cfg.l == 4'd2 && cfg.f == 3'd4)
    else $error("Mode 3 table wrong.");
  mode_single_a: assert property (
    active.mode == 4'd10 |-> cfg.m == 3'd1 && cfg.l == 4'd1 && cfg.s == 2'd1)
    else $error("Mode 10 table wrong.");
  lane_range_a: assert property (
    lane_rate < LANE_MIN |=> config_error_out)
    else $error("Low lane rate not flagged.");
  dense_pack_a: assert property (
    cfg.mode <= 4'd10 && cfg.mode != 4'd8 |-> cfg.hd == (cfg.mode inside {4'd0, 4'd4, 4'd9}))
    else $error("Dense packing mismatch.");
  sample_bits_a: assert property (
    cfg.packed_cfg[7][4:0] == 5'd15 && cfg.packed_cfg[8][4:0] == 5'd15)
    else $error("Sample width field wrong.");
  k_rule_a: assert property (
    active.mode == 4'd9 && !cfg.k32 |=> config_error_out && link_run_out == 2'b00)
    else $error("Short multiframe accepted.");
  link_one_a: assert property (
    !cfg.two_link ##1 !cfg.two_link |=> !link_run_out[1])
    else $error("Second link runs in one-link mode.");
  descramble_a: assert property (
    $changed(cfg.scramble) |=> descramble_enable_out == $past(cfg.scramble))
    else $error("Descramble enable lags.");
  page_reset_a: assert property (
    cfg_wr_in && cfg_addr_in == REG_LINK_RESET && page
    |=> link_reset[1] == $past(cfg_wdata_in[0]) && $stable(link_reset[0]))
    else $error("Paged reset went to wrong link.");
  lane_mask_a: assert property (
    cfg.l == 4'd4 && !cfg.two_link |=> lane_enable_out == 8'h0F)
    else $error("Lane mask wrong.");
  idle_lane_a: assert property (
    cfg_wr_in && cfg_addr_in == REG_IDLE_LANE |=> idle_lane_shutdown_out == $past(cfg_wdata_in))
    else $error("Idle lane mask not stored.");
  conv_shut_a: assert property (
    cfg.m == 3'd1 && cfg.two_link |=> converter_shutdown_mask_out == SHUT_ONE_DUAL)
    else $error("Converter shutdown code wrong.");
  pair_clk_a: assert property (
    pair_b_clock_shutdown_out == ((converter_shutdown_mask_out[1:0] == 2'b11) ? 8'h40 : 8'h00))
    else $error("Pair clock shutdown wrong.");
  serdes_fast_a: assert property (
    band == SRLMC_BAND_FAST |=> serdes_double_rate_out && serdes_loop_divider_out == 2'd0)
    else $error("Fast band SERDES setting wrong.");
  lmfc_align_a: assert property (
    active.subclass && sysref_rise |=> lmfc_cnt == 5'd0 ##1 lmfc_cnt == 5'd1)
    else $error("Multiframe not aligned to sysref.");
  hold_cfg_a: assert property (
    link_en != 2'b00 && next_link_en != 2'b00 |=> $stable(active))
    else $error("Configuration changed under a running link.");

  dual_run_c: cover property (link_run_out == 2'b11);
  sysref_align_c: cover property (active.subclass && sysref_rise);
  cfg_error_c: cover property ($rose(config_error_out));
endmodule

// *** hw/srlmc_pkg.sv ***
package srlmc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PACK_COUNT = 11;
  // Register offsets.
  localparam logic [11:0] REG_MODE = 12'h110;
  localparam logic [11:0] REG_UPSAMPLE = 12'h111;
  localparam logic [11:0] REG_LINK_OPT = 12'h112;
  localparam logic [11:0] REG_PAGE = 12'h113;
  localparam logic [11:0] REG_LINK_RESET = 12'h114;
  localparam logic [11:0] REG_DAC_LO = 12'h115;
  localparam logic [11:0] REG_DAC_HI = 12'h116;
  localparam logic [11:0] REG_STATUS = 12'h117;
  localparam logic [11:0] REG_LANE_EN0 = 12'h118;
  localparam logic [11:0] REG_LANE_EN1 = 12'h119;
  localparam logic [11:0] REG_CFG_SUM = 12'h11A;
  localparam logic [11:0] REG_POWER = 12'h11B;
  localparam logic [11:0] REG_SERDES = 12'h11C;
  localparam logic [11:0] REG_IDLE_LANE = 12'h201;
  localparam logic [11:0] REG_LINK_CTRL = 12'h300;
  localparam logic [11:0] REG_PACK_FIRST = 12'h450;
  localparam logic [11:0] REG_PACK_BANK = 12'h451;
  localparam logic [11:0] REG_PACK_LAST = 12'h45A;
  // Field positions.
  localparam int LC_SUBCLASS_BIT = 3;
  localparam int LC_SUM_BIT = 6;
  localparam int OPT_SCRAMBLE_BIT = 0;
  localparam int OPT_TWO_LINK_BIT = 1;
  localparam int OPT_K32_BIT = 2;
  localparam int OPT_EQ_BIT = 3;
  // Codes and limits.
  localparam logic [7:0] UPS_1X = 8'h00;
  localparam logic [7:0] UPS_2X = 8'h01;
  localparam logic [7:0] UPS_4X = 8'h03;
  localparam logic [7:0] UPS_8X = 8'h04;
  localparam logic [11:0] MAX_DATA_LOW = 12'd1060;
  localparam logic [11:0] MAX_DATA_4X = 12'd700;
  localparam logic [11:0] MAX_DATA_8X = 12'd350;
  localparam logic [17:0] LANE_MIN = 18'd1420;
  localparam logic [17:0] SLOW_MAX = 18'd2760;
  localparam logic [17:0] MID_MIN = 18'd2830;
  localparam logic [17:0] MID_MAX = 18'd5520;
  localparam logic [17:0] FAST_MIN = 18'd5650;
  localparam logic [17:0] LANE_MAX = 18'd10640;
  localparam logic [4:0] LANE_RATE_MULT = 5'd20;
  localparam logic [4:0] SAMPLE_BITS = 5'd16;
  localparam logic [2:0] PROTO_VERSION = 3'd1;
  localparam logic [3:0] SHUT_ONE_SINGLE = 4'b0111;
  localparam logic [3:0] SHUT_ONE_DUAL = 4'b0101;
  localparam logic [3:0] SHUT_TWO_SINGLE = 4'b0011;
  localparam logic [3:0] SHUT_NONE = 4'b0000;
  localparam logic [7:0] PAIR_CLK_OFF = 8'h40;
  localparam logic [7:0] PAIR_CLK_ON = 8'h00;
  localparam logic [3:0] RESET_OPT = 4'h4;
  typedef enum logic [1:0] {
    SRLMC_BAND_SLOW = 2'b00,
    SRLMC_BAND_MID = 2'b01,
    SRLMC_BAND_FAST = 2'b10,
    SRLMC_BAND_NONE = 2'b11
  } srlmc_band_t;
  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] ups;
    logic [3:0] opt;
    logic [11:0] dac;
    logic [7:0] dev_id;
    logic [7:0] bank_id;
    logic subclass;
    logic sum_method;
  } srlmc_cfg_t;
endpackage

// *** hw/srlmc_cfg_if.sv ***
`timescale 1ns/1ps
interface srlmc_cfg_if;
  import srlmc_pkg::*;
  logic [3:0] mode;
  logic two_link;
  logic k32;
  logic scramble;
  logic subclass;
  logic sum_method;
  logic [7:0] dev_id;
  logic [7:0] bank_id;
  logic [2:0] m;
  logic [3:0] l;
  logic [1:0] s;
  logic [2:0] f;
  logic hd;
  logic mode_ok;
  logic [7:0] cfg_sum;
  logic [7:0] packed_cfg [PACK_COUNT];
  modport core (output mode, two_link, k32, scramble, subclass, sum_method, dev_id,
    bank_id, input m, l, s, f, hd, mode_ok, cfg_sum, packed_cfg);
  modport decode (input mode, two_link, output m, l, s, f, hd, mode_ok);
  modport checksum (input m, l, s, hd, k32, scramble, subclass, sum_method, dev_id,
    bank_id, f, output cfg_sum, packed_cfg);
endinterface

// *** hw/srlmc_mode_decode.sv ***
`timescale 1ns/1ps
module srlmc_mode_decode (
  // Mode in, frame parameters out
  srlmc_cfg_if.decode cfg
);
  import srlmc_pkg::*;

  always_comb begin
    cfg.mode_ok = 1'b1;
    unique case (cfg.mode)
      4'd0: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd4, 4'd8, 2'd1, 3'd1};
      4'd1: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd4, 4'd8, 2'd2, 3'd2};
      4'd2: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd4, 4'd4, 2'd1, 3'd2};
      4'd3: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd4, 4'd2, 2'd1, 3'd4};
      4'd4: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd2, 4'd4, 2'd1, 3'd1};
      4'd5: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd2, 4'd4, 2'd2, 3'd2};
      4'd6: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd2, 4'd2, 2'd1, 3'd2};
      4'd7: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd2, 4'd1, 2'd1, 3'd4};
      4'd9: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd1, 4'd2, 2'd1, 3'd1};
      4'd10: {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd1, 4'd1, 2'd1, 3'd2};
      default: begin
        {cfg.m, cfg.l, cfg.s, cfg.f} = {3'd4, 4'd8, 2'd1, 3'd1};
        cfg.mode_ok = 1'b0;
      end
    endcase
    // Four-converter modes use two to eight lanes and cannot be split in two links.
    if (cfg.two_link && cfg.mode < 4'd4) begin
      cfg.mode_ok = 1'b0;
    end
    cfg.hd = (cfg.f == 3'd1);
  end
endmodule

// *** hw/srlmc_config_sum.sv ***
`timescale 1ns/1ps
module srlmc_config_sum (
  // Frame parameters in, packed bytes and sum out
  srlmc_cfg_if.checksum cfg
);
  import srlmc_pkg::*;

  logic [4:0] k_less;
  logic [4:0] n_less;
  logic [7:0] field_sum;
  logic [7:0] reg_sum;

  always_comb begin
    k_less = cfg.k32 ? 5'd31 : 5'd15;
    n_less = SAMPLE_BITS - 5'd1;
    cfg.packed_cfg[0] = cfg.dev_id;
    cfg.packed_cfg[1] = cfg.bank_id;
    cfg.packed_cfg[2] = 8'h00;
    cfg.packed_cfg[3] = {cfg.scramble, 3'd0, 4'(cfg.l - 4'd1)};
    cfg.packed_cfg[4] = {5'd0, 3'(cfg.f - 3'd1)};
    cfg.packed_cfg[5] = {3'd0, k_less};
    cfg.packed_cfg[6] = {5'd0, 3'(cfg.m - 3'd1)};
    cfg.packed_cfg[7] = {3'd0, n_less};
    cfg.packed_cfg[8] = {2'd0, cfg.subclass, n_less};
    cfg.packed_cfg[9] = {PROTO_VERSION, 3'd0, 2'(cfg.s - 2'd1)};
    cfg.packed_cfg[10] = {cfg.hd, 7'd0};
  end

  always_comb begin
    field_sum = ({4'd0, cfg.l} - 8'd1) + ({5'd0, cfg.m} - 8'd1) + {3'd0, k_less}
      + {3'd0, n_less} + {3'd0, n_less} + ({6'd0, cfg.s} - 8'd1)
      + {7'd0, cfg.scramble} + {7'd0, cfg.hd} + {7'd0, cfg.subclass}
      + {5'd0, PROTO_VERSION};
    reg_sum = 8'h00;
    for (int i = 0; i < PACK_COUNT; i++) begin
      reg_sum = reg_sum + cfg.packed_cfg[i];
    end
    cfg.cfg_sum = cfg.sum_method ? reg_sum : field_sum;
  end
endmodule

// *** tb/srlmc_tx_model.sv ***
`timescale 1ns/1ps
module srlmc_tx_model (
  // Clock and request
  input wire logic ref_clk_in,
  input wire logic send_in,
  // Timing strobe
  output logic sysref_out
);
  logic [2:0] hold = 3'h0;
  // Held four cycles so the receiver's two-flop synchroniser cannot miss it.
  always @(posedge ref_clk_in) begin
    hold <= send_in ? 3'h4 : (hold != 3'h0) ? hold - 3'h1 : 3'h0;
  end
  assign sysref_out = (hold != 3'h0);
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, send = 1'b0;
  logic [11:0] cfg_addr_in = 12'h000;
  logic [7:0] cfg_wdata_in = 8'h00, d;
  logic [7:0] cfg_rdata_out, lane_enable_out, idle_lane_shutdown_out, lane_zero_config_sum_out;
  logic [7:0] pair_b_clock_shutdown_out;
  logic [1:0] link_run_out, upsample_stages_out, serdes_loop_divider_out;
  logic [3:0] converter_shutdown_mask_out;
  logic cfg_rvalid_out, descramble_enable_out, subclass_out, lmfc_pulse_out, sysref_in;
  logic serdes_double_rate_out, cdr_oversample_select_out, equalizer_power_select_out;
  logic config_error_out;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  srlmc_core dut (.*);
  srlmc_tx_model tx (.ref_clk_in(ref_clk_in), .send_in(send), .sysref_out(sysref_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    cfg_addr_in = a;
    cfg_wdata_in = v;
    cfg_wr_in = 1'b1;
    wt(1);
    cfg_wr_in = 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    int k;
    cfg_addr_in = a;
    cfg_rd_in = 1'b1;
    wt(1);
    cfg_rd_in = 1'b0;
    for (k = 0; k < 3 && cfg_rvalid_out !== 1'b1; k++) wt(1);
    v = (cfg_rvalid_out === 1'b1) ? cfg_rdata_out : 8'hxx;
    wt(1);
  endtask
  function automatic logic [7:0] serdes();
    return {4'h0, serdes_double_rate_out, cdr_oversample_select_out, serdes_loop_divider_out};
  endfunction
  task automatic t_idle();
    wr(12'h201, 8'hCC);
    chk(idle_lane_shutdown_out, 8'hCC);
    rd(12'h201, d);
    chk(d, 8'hCC);
    rd(12'h3FF, d);
    chk(d, 8'h00);
  endtask
  task automatic t_dual();
    // Mode 6, 2x, 600 MHz DAC: data 300, lane 6000, fast band.
    wr(12'h110, 8'h06);
    wr(12'h111, 8'h01);
    wr(12'h115, 8'h58);
    wr(12'h116, 8'h02);
    wr(12'h112, 8'h0F);
    wr(12'h300, 8'h03);
    wt(3);
    chk({6'h00, link_run_out}, 8'h03);
    chk(lane_enable_out, 8'h33);
    chk({4'h0, converter_shutdown_mask_out}, 8'h00);
    chk(pair_b_clock_shutdown_out, 8'h00);
    chk(serdes(), 8'h08);
    chk({5'h00, descramble_enable_out, equalizer_power_select_out, config_error_out}, 8'h06);
    chk({6'h00, upsample_stages_out}, 8'h01);
    wr(12'h113, 8'h01);
    wr(12'h114, 8'h01);
    wt(2);
    chk({6'h00, link_run_out}, 8'h01);
    rd(12'h114, d);
    chk(d, 8'h01);
    wr(12'h113, 8'h00);
    rd(12'h114, d);
    chk(d, 8'h00);
    wr(12'h110, 8'h09);
    wt(3);
    chk(lane_enable_out, 8'h33);
    wr(12'h300, 8'h00);
  endtask
  task automatic t_single();
    // Mode 9, 8x, 1600 MHz DAC: data 200, lane 2000, slow band.
    wr(12'h111, 8'h04);
    wr(12'h115, 8'h40);
    wr(12'h116, 8'h06);
    wr(12'h112, 8'h04);
    wr(12'h450, 8'h10);
    wr(12'h451, 8'h01);
    wr(12'h300, 8'h09);
    wt(3);
    chk({4'h0, converter_shutdown_mask_out}, 8'h07);
    chk(pair_b_clock_shutdown_out, 8'h40);
    chk(lane_enable_out, 8'h03);
    chk(lane_zero_config_sum_out, 8'h41);
    chk(serdes(), 8'h06);
    chk({6'h00, upsample_stages_out}, 8'h03);
    chk({6'h00, subclass_out, config_error_out}, 8'h02);
    send = 1'b1;
    wt(1);
    send = 1'b0;
    wt(3);
    chk({7'h00, lmfc_pulse_out}, 8'h01);
    wt(31);
    chk({7'h00, lmfc_pulse_out}, 8'h00);
    wt(1);
    chk({7'h00, lmfc_pulse_out}, 8'h01);
    rd(12'h45A, d);
    chk(d, 8'h80);
    wr(12'h300, 8'h00);
    wr(12'h300, 8'h41);
    wt(3);
    chk(lane_zero_config_sum_out, 8'hEF);
    wr(12'h300, 8'h00);
    wr(12'h111, 8'h02);
    wt(3);
    chk({7'h00, config_error_out}, 8'h01);
    wr(12'h111, 8'h04);
    wt(2);
    chk({7'h00, config_error_out}, 8'h00);
    wr(12'h112, 8'h00);
    rd(12'h117, d);
    chk(d, 8'h04);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    wt(20);
    sys_rst_in = 1'b0;
    chk(serdes(), 8'h06);
    chk({6'h00, link_run_out}, 8'h00);
    t_idle();
    t_dual();
    t_single();
    final_report();
  end
endmodule
